// ===== bench/epc_counter_properties.sv
`timescale 1ns/10ps
// Bus handshake and read-back checks at the top ports
module epc_counter_properties
	import epc_pkg::*;
#(
	parameter int TERMS = 8
)(
	input wire logic             CLK_IN,
	input wire logic             RST_IN,
	input wire logic [TERMS-1:0] TERM_IN,
	input wire logic [4:0]       AVS_ADDRESS_IN,
	input wire logic             AVS_READ_IN,
	input wire logic             AVS_WRITE_IN,
	input wire logic [31:0]      AVS_WRITEDATA_IN,
	input wire logic [3:0]       AVS_BYTEENABLE_IN,
	input wire logic [31:0]      AVS_READDATA_OUT,
	input wire logic             AVS_WAITREQUEST_OUT
);
	logic req;
	logic take;
	// Requested accesses, accepted reads only for take
	assign req  = AVS_READ_IN || AVS_WRITE_IN;
	assign take = AVS_READ_IN && AVS_WAITREQUEST_OUT;

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	AST_ANSWER: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
		else $error("access not answered after one wait cycle");
	AST_ONE_WAIT: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("waitrequest low for more than one cycle");
	AST_CAUSE: assert property ($fell(AVS_WAITREQUEST_OUT)
		|-> $past(AVS_READ_IN) || $past(AVS_WRITE_IN))
		else $error("waitrequest dropped without a request");
	AST_RST_IDLE: assert property (disable iff (1'b0) RST_IN
		|=> AVS_WAITREQUEST_OUT && AVS_READDATA_OUT == 32'h0)
		else $error("bus not idle after reset");
	AST_HOLD: assert property (!take |=> $stable(AVS_READDATA_OUT))
		else $error("read data changed without a read");
	AST_UNMAPPED: assert property (take && AVS_ADDRESS_IN[4:2] == 3'h7
		|=> AVS_READDATA_OUT == 32'h0)
		else $error("unmapped read not zero");
	AST_CTRL_ACT: assert property (take && AVS_ADDRESS_IN[4:2] == EPC_OFS_CTRL[4:2]
		|=> AVS_READDATA_OUT[1:0] == 2'h0)
		else $error("start or stop bit reads back set");
	AST_LEVEL: assert property (take && AVS_ADDRESS_IN[4:2] == EPC_OFS_STATUS[4:2]
		|=> AVS_READDATA_OUT[3] == (AVS_READDATA_OUT[12:8] == 5'h0))
		else $error("empty flag disagrees with level");
endmodule

bind epc_counter epc_counter_properties #(.TERMS(TERMS)) u_props (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .TERM_IN(TERM_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
	.AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT)
);

// ===== bench/epc_counter_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			err_count++; \
			$display("FAIL %s expected %h seen %h", nm, exp, got); \
		end \
	end
module epc_counter_tb;
	import epc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        arm = 1'b0;
	logic        smp = 1'b0;
	logic        enc_a;
	logic        enc_b;
	logic        enc_z;
	logic [7:0]  term;
	logic [4:0]  adr = 5'h00;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdata;
	logic        wait_rq;
	logic [31:0] v;
	int          err_count = 0;
	int          n_compared = 0;

	// 125 MHz clock
	always #4 clk = ~clk;
	// Upper terminals carry B and A swapped, so a wrong select reverses direction
	assign term = {enc_z, enc_a, enc_b, smp, arm, enc_z, enc_b, enc_a};

	epc_counter DUT (
		.CLK_IN              (clk),
		.RST_IN              (rst),
		.TERM_IN             (term),
		.AVS_ADDRESS_IN      (adr),
		.AVS_READ_IN         (rd_en),
		.AVS_WRITE_IN        (wr_en),
		.AVS_WRITEDATA_IN    (wdata),
		.AVS_BYTEENABLE_IN   (be),
		.AVS_READDATA_OUT    (rdata),
		.AVS_WAITREQUEST_OUT (wait_rq)
	);
	epc_encoder_model u_enc (
		.clk_in (clk),
		.a_out  (enc_a),
		.b_out  (enc_b),
		.z_out  (enc_z)
	);

	// One bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		rd_en <= !w;
		wr_en <= w;
		adr <= a;
		wdata <= d;
		// No assumed latency; only the watchdog ends a hung access
		do
			@(posedge clk);
		while (wait_rq !== 1'b0);
		v = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic chk(input logic [4:0] a, input logic [31:0] exp, input string nm);
		bus(1'b0, a, 32'h0);
		`CHK(nm, exp, v)
	endtask
	// Full quadrature cycle, then settle
	task automatic cycle(input int dir, input int hold);
		repeat (4) u_enc.step(dir, hold);
		repeat (10) @(posedge clk);
	endtask
	// Level on arm (0) or sample (1) terminal
	task automatic lvl(input int i, input logic l);
		@(posedge clk);
		if (i == 0)
			arm <= l;
		else
			smp <= l;
		repeat (8) @(posedge clk);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard, well past the expected run
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		logic [1:0] modes [3];
		int         k;
		modes = '{EPC_DEC_X1, EPC_DEC_X2, EPC_DEC_X4};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk(EPC_OFS_SELECT, 32'h00043210, "select reset"); // defaults
		chk(EPC_OFS_COUNT, 32'h0, "count reset"); // width
		chk(EPC_OFS_STATUS, 32'h8, "status reset"); // idle
		chk(5'h1C, 32'h0, "unmapped"); // map
		for (int m = 0; m < 3; m++)
		begin
			k = 1 << m;
			wr(EPC_OFS_CTRL, {28'h0, modes[m], 2'h1});
			chk(EPC_OFS_CTRL, {28'h0, modes[m], 2'h0}, "ctrl"); // type
			wr(EPC_OFS_COUNT, 32'h1);
			cycle(1, 4);
			chk(EPC_OFS_COUNT, 32'(1 + k), "count up");
			cycle(-1, 12);
			cycle(-1, 4);
			chk(EPC_OFS_COUNT, 32'(1 - k), "count down");
		end
		wr(EPC_OFS_CTRL, {28'h0, EPC_DEC_TWO_PULSE, 2'h1});
		wr(EPC_OFS_COUNT, 32'h10);
		repeat (3) u_enc.pulse(1, 4);
		u_enc.pulse(0, 4);
		repeat (10) @(posedge clk);
		chk(EPC_OFS_COUNT, 32'h12, "two pulse");
		wr(EPC_OFS_CTRL, {28'h0, EPC_DEC_X4, 2'h1});
		for (int p = 0; p < 4; p++)
		begin
			wr(EPC_OFS_INDEX, 32'(p * 2 + 1));
			wr(EPC_OFS_INDEX_VAL, 32'hA0 + 32'(p));
			chk(EPC_OFS_INDEX, 32'(p * 2 + 1), "index cfg"); // held
			while ({enc_a, enc_b} != 2'(p))
				u_enc.step(1, 4);
			u_enc.step(-1, 4);
			u_enc.set_z(1'b1);
			u_enc.step(1, 4);
			repeat (6) @(posedge clk);
			u_enc.set_z(1'b0);
			repeat (6) @(posedge clk);
			chk(EPC_OFS_COUNT, 32'hA0 + 32'(p), "reload");
			u_enc.step(1, 4);
			repeat (8) @(posedge clk);
			chk(EPC_OFS_COUNT, 32'hA1 + 32'(p), "after reload"); // resumes
		end
		wr(EPC_OFS_INDEX, 32'h0);
		wr(EPC_OFS_SELECT, 32'h00043265);
		wr(EPC_OFS_COUNT, 32'h0);
		cycle(1, 4);
		chk(EPC_OFS_COUNT, 32'hFFFFFFFC, "routed"); // select
		wr(EPC_OFS_SELECT, 32'h00043210);
		for (int e = 0; e < 2; e++)
		begin
			wr(EPC_OFS_CTRL, 32'h2);
			lvl(0, e == 0);
			wr(EPC_OFS_COUNT, 32'h0);
			wr(EPC_OFS_CTRL, {26'h0, 1'(e), 1'b1, EPC_DEC_X4, 2'h1});
			lvl(0, e != 0);
			chk(EPC_OFS_STATUS, 32'hA, "armed wait");
			cycle(1, 4);
			chk(EPC_OFS_COUNT, 32'h0, "held off"); // held
			lvl(0, e == 0);
			chk(EPC_OFS_STATUS, 32'h9, "armed run"); // edge
			cycle(1, 4);
			chk(EPC_OFS_COUNT, 32'h4, "armed count"); // started
		end
		wr(EPC_OFS_CTRL, {25'h0, 1'b1, 2'h0, EPC_DEC_X4, 2'h1});
		wr(EPC_OFS_COUNT, 32'h40);
		for (int i = 0; i < 3; i++)
		begin
			u_enc.step(1, 4);
			repeat (6) @(posedge clk);
			lvl(1, 1'b1);
			lvl(1, 1'b0);
		end
		chk(EPC_OFS_STATUS, 32'h301, "buffer level"); // stored
		for (int i = 0; i < 3; i++)
			chk(EPC_OFS_BUF_DATA, 32'h41 + 32'(i), "sample"); // order
		chk(EPC_OFS_BUF_DATA, 32'h0, "buffer empty"); // drained
		// Seventeen samples into sixteen places: last one dropped
		for (int i = 0; i < 17; i++)
		begin
			lvl(1, 1'b1);
			lvl(1, 1'b0);
		end
		chk(EPC_OFS_STATUS, 32'h1015, "buffer full"); // depth
		wr(EPC_OFS_STATUS, 32'h4);
		chk(EPC_OFS_STATUS, 32'h1011, "overflow clear"); // sticky
		end_sim();
	end
endmodule

// ===== bench/epc_encoder_model.sv
`timescale 1ns/10ps
// Behavioural quadrature or two-pulse encoder
module epc_encoder_model (
	input  wire logic clk_in,
	output logic      a_out,
	output logic      b_out,
	output logic      z_out
);
	logic [1:0] pos = 2'h0;
	// Lines start low, index inactive
	initial
	begin
		a_out = 1'b0;
		b_out = 1'b0;
		z_out = 1'b0;
	end
	task automatic step(input int dir, input int hold);
		pos = pos + 2'(dir);
		@(posedge clk_in);
		a_out <= pos[1] ^ pos[0];
		b_out <= pos[1];
		repeat (hold) @(posedge clk_in);
	endtask
	task automatic pulse(input int on_a, input int hold);
		@(posedge clk_in);
		if (on_a != 0)
			a_out <= 1'b1;
		else
			b_out <= 1'b1;
		repeat (hold) @(posedge clk_in);
		a_out <= 1'b0;
		b_out <= 1'b0;
		repeat (hold) @(posedge clk_in);
	endtask
	task automatic set_z(input logic lvl);
		@(posedge clk_in);
		z_out <= lvl;
	endtask
endmodule

// ===== hw/epc_counter.sv
`timescale 1ns/10ps
// Overview of operation
// - X1: count up on A rising edge when A leads B.
// - X1: count down on A falling edge when B leads A.
// - X2: count on every A edge, direction from leading channel.
// - X4: count on every edge of both A and B.
// - X4: up or down chosen by which channel leads.
// - Index enabled, except in two-pulse: load index value while Z high in chosen phase.
// - Reload phase selectable as any one of four A/B states.
// - Count edge applied first, reload follows on a later tick.
// - Reload done within one timebase period of phase becoming true.
// - Counting continues normally from the reloaded value.
// - Two-pulse: count up on each A rising edge.
// - Two-pulse: count down on each B rising edge.
// - Decoding type selects two-pulse, X1, X2 or X4.
// - Index enable, reload phase and reload value are held.
// - A, B and Z routed from selectable terminals with defaults.
// - On-demand: counting starts at start, every read returns count.
// - Sample clock: count stored in buffer on each rising edge while not full.
// - Armed start waits for a digital edge on the trigger source.
// - Arming edge selectable as rising or falling.
// - Counter clocked from a 100 MHz timebase.
// - Count up when A leads B, down when B leads A.
module epc_counter
	import epc_pkg::*;
#(
	parameter int TERMS     = 8,
	parameter int SEL_W     = 3,
	parameter int BUF_DEPTH = 16,
	parameter int LVL_W     = 5
)(
	input  wire logic             CLK_IN,
	input  wire logic             RST_IN,
	input  wire logic [TERMS-1:0] TERM_IN,
	input  wire logic [4:0]       AVS_ADDRESS_IN,
	input  wire logic             AVS_READ_IN,
	input  wire logic             AVS_WRITE_IN,
	input  wire logic [31:0]      AVS_WRITEDATA_IN,
	input  wire logic [3:0]       AVS_BYTEENABLE_IN,
	output logic      [31:0]      AVS_READDATA_OUT,
	output logic                  AVS_WAITREQUEST_OUT
);

	typedef struct packed {
		logic                          waitreq;
		logic [31:0]                   rdata;
		epc_decode_type                decode;
		logic                          arm_en;
		logic                          arm_fall;
		logic                          sample_mode;
		logic                          idx_en;
		logic [1:0]                    idx_phase;
		logic [31:0]                   idx_val;
		logic [SEL_W-1:0]              sel_a;
		logic [SEL_W-1:0]              sel_b;
		logic [SEL_W-1:0]              sel_z;
		logic [SEL_W-1:0]              sel_arm;
		logic [SEL_W-1:0]              sel_smp;
		logic [7:0]                    tb_acc;
		logic [TERMS-1:0]              sync1;
		logic [TERMS-1:0]              sync2;
		logic [TERMS-1:0]              prev;
		logic                          running;
		logic                          arm_wait;
		logic [31:0]                   count;
		logic [BUF_DEPTH-1:0][31:0]    mem;
		logic [LVL_W-1:0]              wr_ptr;
		logic [LVL_W-1:0]              rd_ptr;
		logic [LVL_W-1:0]              level;
		logic                          overflow;
	} epc_state_type;

	localparam logic [LVL_W-1:0] LVL_ONE  = LVL_W'(1);
	localparam logic [LVL_W-1:0] LVL_LAST = LVL_W'(BUF_DEPTH - 1);
	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(BUF_DEPTH);

	epc_state_type s;
	epc_state_type next_s;

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	// Combinational next-state of the whole channel
	always_comb
	begin
		logic        tick;
		logic [8:0]  acc_sum;
		logic        a;
		logic        b;
		logic        z;
		logic        a_rise;
		logic        a_fall;
		logic        b_rise;
		logic        b_fall;
		logic        arm_lvl;
		logic        arm_prev;
		logic        smp_rise;
		logic        up;
		logic        down;
		logic        ab_edge;
		logic        push;
		logic        pop;
		logic        ovf_set;
		logic        ovf_clr;
		logic [31:0] ctrl_img;
		logic [31:0] idx_img;
		logic [31:0] sel_img;
		logic [31:0] stat_img;
		logic [31:0] wimg;
		logic        req;

		next_s   = s;
		tick     = 1'b0;
		acc_sum  = 9'h000;
		up       = 1'b0;
		down     = 1'b0;
		push     = 1'b0;
		pop      = 1'b0;
		ovf_set  = 1'b0;
		ovf_clr  = 1'b0;
		wimg     = 32'h00000000;
		req      = AVS_READ_IN | AVS_WRITE_IN;
		a        = 1'b0;
		b        = 1'b0;
		z        = 1'b0;
		a_rise   = 1'b0;
		a_fall   = 1'b0;
		b_rise   = 1'b0;
		b_fall   = 1'b0;
		arm_lvl  = 1'b0;
		arm_prev = 1'b0;
		smp_rise = 1'b0;
		ab_edge  = 1'b0;
		ctrl_img = 32'h00000000;
		idx_img  = 32'h00000000;
		sel_img  = 32'h00000000;
		stat_img = 32'h00000000;

		next_s.sync1 = TERM_IN;
		next_s.sync2 = s.sync1;

		// fractional divider, 4 ticks out of 5 clocks
		acc_sum       = {1'b0, s.tb_acc} + {1'b0, EPC_TB_STEP};
		tick          = (acc_sum >= {1'b0, EPC_TB_MOD});
		next_s.tb_acc = tick ? 8'(acc_sum - {1'b0, EPC_TB_MOD}) : acc_sum[7:0];

		a        = s.sync2[s.sel_a];
		b        = s.sync2[s.sel_b];
		z        = s.sync2[s.sel_z];
		arm_lvl  = s.sync2[s.sel_arm];
		arm_prev = s.prev[s.sel_arm];
		a_rise   = tick & a & ~s.prev[s.sel_a];
		a_fall   = tick & ~a & s.prev[s.sel_a];
		b_rise   = tick & b & ~s.prev[s.sel_b];
		b_fall   = tick & ~b & s.prev[s.sel_b];
		smp_rise = tick & s.sync2[s.sel_smp] & ~s.prev[s.sel_smp];
		ab_edge  = a_rise | a_fall | b_rise | b_fall;
		if (tick)
			next_s.prev = s.sync2;

		case (s.decode)
			EPC_DEC_X1:
			begin
				// up on A rise while B low
				up   = a_rise & ~b;
				// down on A fall while B low
				down = a_fall & ~b;
			end
			EPC_DEC_X2:
			begin
				// both A edges, direction from lead
				up   = (a_rise & ~b) | (a_fall & b);
				down = (a_rise & b) | (a_fall & ~b);
			end
			EPC_DEC_X4:
			begin
				// all edges of A and B, lead sets direction
				up   = (a_rise & ~b) | (a_fall & b) | (b_rise & a) | (b_fall & ~a);
				down = (a_rise & b) | (a_fall & ~b) | (b_rise & ~a) | (b_fall & a);
			end
			EPC_DEC_TWO_PULSE:
			begin
				up   = a_rise;
				down = b_rise;
			end
			default:
				up = 1'b0;
		endcase

		// arming edge releases the held-off start
		if (s.arm_wait && tick && (s.arm_fall ? (arm_prev & ~arm_lvl) : (arm_lvl & ~arm_prev)))
		begin
			next_s.arm_wait = 1'b0;
			next_s.running  = 1'b1;
		end

		// Count update, wraps naturally at 32 bits
		if (s.running)
		begin
			if (up && !down)
				next_s.count = s.count + 32'h00000001;
			else if (down && !up)
				next_s.count = s.count - 32'h00000001;
			// reload only on a tick without an A/B edge
			// Z high in the selected A/B phase
			// on the next timebase tick after entering the phase
			// decoding goes on from the loaded value
			else if (tick && !ab_edge && s.idx_en && (s.decode != EPC_DEC_TWO_PULSE)
				&& z && ({a, b} == s.idx_phase))
				next_s.count = s.idx_val;
		end

		// capture into buffer on the sample clock edge
		if (s.running && s.sample_mode && smp_rise)
		begin
			// Full buffer drops the sample and flags overflow
			ovf_set = (s.level == LVL_FULL);
			push    = (s.level != LVL_FULL);
		end

		// Register images for read-back and byte-lane writes
		ctrl_img[EPC_CTRL_DECODE_POS +: 2] = s.decode;
		ctrl_img[EPC_CTRL_ARM_EN_POS]      = s.arm_en;
		ctrl_img[EPC_CTRL_ARM_FALL_POS]    = s.arm_fall;
		ctrl_img[EPC_CTRL_SAMPLE_POS]      = s.sample_mode;
		// index enable, phase and value held in registers
		idx_img[EPC_IDX_EN_POS]          = s.idx_en;
		idx_img[EPC_IDX_PHASE_POS +: 2]  = s.idx_phase;
		sel_img[EPC_SEL_A_POS +: SEL_W]   = s.sel_a;
		sel_img[EPC_SEL_B_POS +: SEL_W]   = s.sel_b;
		sel_img[EPC_SEL_Z_POS +: SEL_W]   = s.sel_z;
		sel_img[EPC_SEL_ARM_POS +: SEL_W] = s.sel_arm;
		sel_img[EPC_SEL_SMP_POS +: SEL_W] = s.sel_smp;
		stat_img[EPC_ST_RUN_POS]   = s.running;
		stat_img[EPC_ST_WAIT_POS]  = s.arm_wait;
		stat_img[EPC_ST_OVF_POS]   = s.overflow;
		stat_img[EPC_ST_EMPTY_POS] = (s.level == '0);
		stat_img[EPC_ST_FULL_POS]  = (s.level == LVL_FULL);
		stat_img[EPC_ST_LEVEL_POS +: LVL_W] = s.level;

		// Bus slave: accept while waitrequest high, release a cycle later
		next_s.waitreq = 1'b1;
		if (req && s.waitreq)
		begin
			next_s.waitreq = 1'b0;
			if (AVS_READ_IN)
			begin
				// Only a read replaces the held read data
				next_s.rdata = 32'h00000000;
				case ({AVS_ADDRESS_IN[4:2], 2'b00})
					EPC_OFS_CTRL:      next_s.rdata = ctrl_img;
					EPC_OFS_INDEX:     next_s.rdata = idx_img;
					EPC_OFS_INDEX_VAL: next_s.rdata = s.idx_val;
					EPC_OFS_SELECT:    next_s.rdata = sel_img;
					EPC_OFS_COUNT:     next_s.rdata = s.count;
					EPC_OFS_BUF_DATA:
					begin
						if (s.level != '0)
						begin
							next_s.rdata = s.mem[s.rd_ptr];
							pop          = 1'b1;
						end
					end
					EPC_OFS_STATUS:    next_s.rdata = stat_img;
					default:           next_s.rdata = 32'h00000000;
				endcase
			end
			else
			begin
				case ({AVS_ADDRESS_IN[4:2], 2'b00})
					EPC_OFS_CTRL:
					begin
						wimg = merge_be(ctrl_img, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
						next_s.decode      = epc_decode_type'(wimg[EPC_CTRL_DECODE_POS +: 2]);
						next_s.arm_en      = wimg[EPC_CTRL_ARM_EN_POS];
						next_s.arm_fall    = wimg[EPC_CTRL_ARM_FALL_POS];
						next_s.sample_mode = wimg[EPC_CTRL_SAMPLE_POS];
						// Stop wins over start written together
						if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[EPC_CTRL_STOP_POS])
						begin
							next_s.running  = 1'b0;
							next_s.arm_wait = 1'b0;
						end
						else if (AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[EPC_CTRL_START_POS])
						begin
							// start counts at once unless armed
							// armed start waits for the trigger
							next_s.running  = ~wimg[EPC_CTRL_ARM_EN_POS];
							next_s.arm_wait = wimg[EPC_CTRL_ARM_EN_POS];
						end
					end
					EPC_OFS_INDEX:
					begin
						wimg = merge_be(idx_img, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
						next_s.idx_en    = wimg[EPC_IDX_EN_POS];
						next_s.idx_phase = wimg[EPC_IDX_PHASE_POS +: 2];
					end
					EPC_OFS_INDEX_VAL:
					begin
						next_s.idx_val = merge_be(s.idx_val, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					end
					EPC_OFS_SELECT:
					begin
						wimg = merge_be(sel_img, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
						next_s.sel_a   = wimg[EPC_SEL_A_POS +: SEL_W];
						next_s.sel_b   = wimg[EPC_SEL_B_POS +: SEL_W];
						next_s.sel_z   = wimg[EPC_SEL_Z_POS +: SEL_W];
						next_s.sel_arm = wimg[EPC_SEL_ARM_POS +: SEL_W];
						next_s.sel_smp = wimg[EPC_SEL_SMP_POS +: SEL_W];
					end
					EPC_OFS_COUNT:
					begin
						// Software preset; a same-cycle count edge is lost
						next_s.count = merge_be(s.count, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					end
					EPC_OFS_STATUS:
					begin
						ovf_clr = AVS_BYTEENABLE_IN[0] & AVS_WRITEDATA_IN[EPC_ST_OVF_POS];
					end
					default:
					begin
						wimg = 32'h00000000;
					end
				endcase
			end
		end

		// Buffer pointers; a push while full never happens
		if (push)
		begin
			next_s.mem[s.wr_ptr] = s.count;
			next_s.wr_ptr = (s.wr_ptr == LVL_LAST) ? '0 : s.wr_ptr + LVL_ONE;
		end
		if (pop)
			next_s.rd_ptr = (s.rd_ptr == LVL_LAST) ? '0 : s.rd_ptr + LVL_ONE;
		if (push && !pop)
			next_s.level = s.level + LVL_ONE;
		else if (pop && !push)
			next_s.level = s.level - LVL_ONE;

		// Overflow sticky: a new overflow beats the clear
		if (ovf_set)
			next_s.overflow = 1'b1;
		else if (ovf_clr)
			next_s.overflow = 1'b0;
	end

	// State register with synchronous reset
	always_ff @(posedge CLK_IN)
	begin
		if (RST_IN)
		begin
			s             <= '0;
			s.waitreq     <= 1'b1;
			s.decode      <= EPC_DEC_X1;
			s.idx_val     <= EPC_RST_IDX_VAL;
			s.count       <= EPC_RST_COUNT;
			s.sel_a       <= SEL_W'(EPC_RST_SEL_A);
			s.sel_b       <= SEL_W'(EPC_RST_SEL_B);
			s.sel_z       <= SEL_W'(EPC_RST_SEL_Z);
			s.sel_arm     <= SEL_W'(EPC_RST_SEL_ARM);
			s.sel_smp     <= SEL_W'(EPC_RST_SEL_SMP);
		end
		else
		begin
			s <= next_s;
		end
	end

	// Bus outputs straight from state flops
	assign AVS_READDATA_OUT    = s.rdata;
	assign AVS_WAITREQUEST_OUT = s.waitreq;

endmodule

// ===== include/epc_pkg.sv
package epc_pkg;
	// Register byte offsets
	localparam logic [4:0] EPC_OFS_CTRL     = 5'h00;
	localparam logic [4:0] EPC_OFS_INDEX    = 5'h04;
	localparam logic [4:0] EPC_OFS_INDEX_VAL = 5'h08;
	localparam logic [4:0] EPC_OFS_SELECT   = 5'h0C;
	localparam logic [4:0] EPC_OFS_COUNT    = 5'h10;
	localparam logic [4:0] EPC_OFS_BUF_DATA = 5'h14;
	localparam logic [4:0] EPC_OFS_STATUS   = 5'h18;
	// Control field positions
	localparam int EPC_CTRL_START_POS  = 0;
	localparam int EPC_CTRL_STOP_POS   = 1;
	localparam int EPC_CTRL_DECODE_POS = 2;
	localparam int EPC_CTRL_ARM_EN_POS = 4;
	localparam int EPC_CTRL_ARM_FALL_POS = 5;
	localparam int EPC_CTRL_SAMPLE_POS = 6;
	// Index configuration field positions
	localparam int EPC_IDX_EN_POS    = 0;
	localparam int EPC_IDX_PHASE_POS = 1;
	// Terminal select field positions
	localparam int EPC_SEL_A_POS   = 0;
	localparam int EPC_SEL_B_POS   = 4;
	localparam int EPC_SEL_Z_POS   = 8;
	localparam int EPC_SEL_ARM_POS = 12;
	localparam int EPC_SEL_SMP_POS = 16;
	// Status field positions
	localparam int EPC_ST_RUN_POS   = 0;
	localparam int EPC_ST_WAIT_POS  = 1;
	localparam int EPC_ST_OVF_POS   = 2;
	localparam int EPC_ST_EMPTY_POS = 3;
	localparam int EPC_ST_FULL_POS  = 4;
	localparam int EPC_ST_LEVEL_POS = 8;
	// Reset values
	localparam logic [2:0] EPC_RST_SEL_A   = 3'h0;
	localparam logic [2:0] EPC_RST_SEL_B   = 3'h1;
	localparam logic [2:0] EPC_RST_SEL_Z   = 3'h2;
	localparam logic [2:0] EPC_RST_SEL_ARM = 3'h3;
	localparam logic [2:0] EPC_RST_SEL_SMP = 3'h4;
	localparam logic [31:0] EPC_RST_COUNT  = 32'h00000000;
	localparam logic [31:0] EPC_RST_IDX_VAL = 32'h00000000;
	// Timebase: 100 MHz enable derived from the 125 MHz clock
	localparam int EPC_CLK_MHZ      = 125;
	localparam int EPC_TIMEBASE_MHZ = 100;
	localparam logic [7:0] EPC_TB_STEP = 8'(EPC_TIMEBASE_MHZ);
	localparam logic [7:0] EPC_TB_MOD  = 8'(EPC_CLK_MHZ);
	// Decoding types
	typedef enum logic [1:0] {
		EPC_DEC_X1        = 2'h0,
		EPC_DEC_X2        = 2'h1,
		EPC_DEC_X4        = 2'h3,
		EPC_DEC_TWO_PULSE = 2'h2
	} epc_decode_type;
endpackage
